// ---- common/twbc_pkg.sv ----
package twbc_pkg;

	// Core clock rate
	localparam int CLK_HZ           = 50_000_000;
	localparam int CYC_PER_US       = CLK_HZ / 1_000_000;

	// Stuck-bus timeout, in microseconds and in cycles
	localparam int TIMEOUT_US       = 30_000;
	localparam int TIMEOUT_CYC      = TIMEOUT_US * CYC_PER_US;

	// Least wait between fault and first recovery pulse
	localparam int REC_WAIT_US      = 40;
	localparam int REC_WAIT_CYC     = REC_WAIT_US * CYC_PER_US;

	// Recovery clock rate; half period rounds down
	localparam int REC_FREQ_HZ      = 8_500;
	localparam int REC_HALF_CYC     = CLK_HZ / (2 * REC_FREQ_HZ);
	localparam int REC_PULSES       = 16;

	// Backplane idle interval, in microseconds and in cycles
	localparam int IDLE_US          = 100;
	localparam int IDLE_CYC         = IDLE_US * CYC_PER_US;

	// Cycles a released joined line is ignored while the pin settles
	localparam int JOIN_SETTLE_CYC  = 4;

	// Counter widths
	localparam int TMR_W            = 21;
	localparam int IDLE_W           = 13;
	localparam int REC_W            = 12;
	localparam int PULSE_W          = 5;
	localparam int SETTLE_W         = 3;

	// Synchroniser bit positions
	localparam int SYNC_W           = 6;
	localparam int SY_LOCK          = 0;
	localparam int SY_EN            = 1;
	localparam int SY_BP_DATA       = 2;
	localparam int SY_BP_CLK        = 3;
	localparam int SY_CARD_DATA     = 4;
	localparam int SY_CARD_CLK      = 5;

	// Values after reset
	localparam logic FAULT_N_RST    = 1'b1;
	localparam logic READY_RST      = 1'b0;
	// Locked out, disabled, lines idle high: no false edge follows reset
	localparam logic [SYNC_W-1:0] SYNC_RST = 6'h3D;

	// Connection controller states
	typedef enum logic [6:0] {
		ST_LOCKOUT   = 7'h01,
		ST_WAIT_END  = 7'h02,
		ST_WAIT_CARD = 7'h04,
		ST_CONNECTED = 7'h08,
		ST_FLT_WAIT  = 7'h10,
		ST_RECOVER   = 7'h20,
		ST_FLT_HOLD  = 7'h40
	} twbc_state_e;

	// Which side currently owns a low on a joined pair
	typedef enum logic [3:0] {
		JO_NONE   = 4'h1,
		JO_BP     = 4'h2,
		JO_CARD   = 4'h4,
		JO_SETTLE = 4'h8
	} twbc_owner_e;

endpackage

// ---- tb/twbc_bus_model.sv ----
`timescale 1ns/10ps

module twbc_bus_model (
	// Pin values and pull-down enables of the block, enables low active
	input  wire logic [3:0] pinOut,
	input  wire logic [3:0] pullOe_n,
	// Far-side parties holding a line low
	input  wire logic [3:0] holdLow,
	// Line levels: bp data, bp clock, card data, card clock
	output logic      [3:0] level
);
	// Pulled-up lines: an enabled pin shows its value, a held line reads low
	assign level = (pullOe_n | pinOut) & ~holdLow;
endmodule // twbc_bus_model

// ---- tb/twbc_ctrl_asserts.sv ----
`timescale 1ns/10ps

module twbc_ctrl_asserts
	import twbc_pkg::*;
#(
	parameter int TIMEOUT_CYC_P = TIMEOUT_CYC,
	parameter int IDLE_CYC_P    = IDLE_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Supply and enable
	input wire logic supplyLockout,
	input wire logic enable,
	// Line levels
	input wire logic backplaneDataIn,
	input wire logic cardDataIn,
	input wire logic cardClockIn,
	// Pull-down enables
	input wire logic backplaneDataOe_n,
	input wire logic backplaneClockOe_n,
	input wire logic cardDataOe_n,
	input wire logic cardClockOe_n,
	// Status
	input wire logic ready,
	input wire logic fault_n
);
	int lowCnt;
	int fltCnt;
	int pulseCnt;

	// Cycles since card lines were both high, cycles in fault, pulses sent
	always_ff @(posedge core_clk) begin
		if (!nrst || supplyLockout || (cardDataIn && cardClockIn))
			lowCnt <= 0;
		else
			lowCnt <= lowCnt + 1;
		fltCnt <= (!nrst || fault_n) ? 0 : fltCnt + 1;
		if (!nrst || fault_n)
			pulseCnt <= 0;
		else if ($fell(cardClockOe_n))
			pulseCnt <= pulseCnt + 1;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	chk_lockout_apart: assert property (supplyLockout [*5] |-> !ready && cardDataOe_n)
		else $error("pins touched in lockout");
	chk_ready_cause: assert property ($rose(ready) && $past(fault_n) |->
		$past(enable, 3) && $past(cardDataIn, 3) && $past(cardClockIn, 3))
		else $error("joined without start-up conditions");
	chk_copy_data: assert property ((ready && !backplaneDataIn && backplaneDataOe_n) [*8]
		|-> !cardDataOe_n)
		else $error("data low not copied to card");
	chk_copy_clock: assert property ((ready && !cardClockIn && cardClockOe_n) [*8]
		|-> !backplaneClockOe_n)
		else $error("clock low not copied to backplane");
	chk_fault_time: assert property ($fell(fault_n) |-> lowCnt >= TIMEOUT_CYC_P)
		else $error("fault before timeout");
	chk_fault_apart: assert property (!fault_n [*2] |-> !ready)
		else $error("joined during fault");
	chk_rec_wait: assert property (!cardClockOe_n && fltCnt > 4 |-> fltCnt >= REC_WAIT_CYC)
		else $error("recovery pulse too early");
	chk_pulse_cap: assert property (pulseCnt <= REC_PULSES)
		else $error("too many recovery pulses");
	chk_enable_off: assert property (!enable [*5] |-> !ready && cardClockOe_n)
		else $error("active while disabled");
	chk_fault_clear: assert property ($rose(fault_n) && !ready |->
		$past(cardDataIn, 3) && $past(cardClockIn, 3))
		else $error("fault released with card low");
endmodule // twbc_ctrl_asserts

bind twbc_ctrl twbc_ctrl_asserts #(
	.TIMEOUT_CYC_P(TIMEOUT_CYC_P),
	.IDLE_CYC_P(IDLE_CYC_P)
) chk (.*);

// ---- tb/twbc_ctrl_tb.sv ----
`timescale 1ns/10ps

module twbc_ctrl_tb
	import twbc_pkg::*;
;
	localparam int SIM_TMO  = 200;
	localparam int SIM_IDLE = 50;

	logic       core_clk    = 1'b0;
	logic       nrst        = 1'b0;
	logic [5:0] drv         = 6'h00; // lockout, enable, holds: card clk/data, bp clk/data
	logic [3:0] oe_n;
	logic [3:0] pinOut;
	logic [3:0] level;
	logic       ready;
	logic       fault_n;
	int         miscompares = 0;
	int         n_compared  = 0;

	// 50 MHz core clock
	always #10 core_clk = ~core_clk;

	// Far-side parties and pull-ups
	twbc_bus_model model (.pinOut(pinOut), .pullOe_n(oe_n), .holdLow(drv[3:0]),
		.level(level));

	twbc_ctrl #(.TIMEOUT_CYC_P(SIM_TMO), .IDLE_CYC_P(SIM_IDLE)) uut (
		.core_clk(core_clk), .nrst(nrst), .supplyLockout(drv[5]), .enable(drv[4]),
		.backplaneDataIn(level[0]), .backplaneDataOut(pinOut[0]),
		.backplaneDataOe_n(oe_n[0]),
		.backplaneClockIn(level[1]), .backplaneClockOut(pinOut[1]),
		.backplaneClockOe_n(oe_n[1]),
		.cardDataIn(level[2]), .cardDataOut(pinOut[2]), .cardDataOe_n(oe_n[2]),
		.cardClockIn(level[3]), .cardClockOut(pinOut[3]), .cardClockOe_n(oe_n[3]),
		.ready(ready), .fault_n(fault_n));

	// Prints counts and verdict, then stops
	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One comparison
	task automatic check(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask

	// Settled sampling point n cycles on
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Drive pins at a rising edge
	task automatic set(input logic [5:0] v);
		@(posedge core_clk);
		drv <= v;
		tick(1);
	endtask

	// Reset for ten cycles with given pins
	task automatic restart(input logic [5:0] v);
		@(posedge core_clk);
		nrst <= 1'b0;
		drv <= v;
		tick(10);
		@(posedge core_clk);
		nrst <= 1'b1;
		tick(1);
	endtask

	// Bounded wait on ready (0), fault_n (1) or card clock pull (2)
	task automatic await(input int sel, input logic val, input int lim, output int cyc);
		cyc = 0;
		while (((sel == 0) ? ready : (sel == 1) ? fault_n : oe_n[3]) !== val) begin
			tick(1);
			cyc++;
			if (cyc > lim) begin
				miscompares++;
				$display("CHECK FAILED %0t wait ran out", $time);
				end_of_test();
			end
		end
	endtask

	// Stuck card at power-up, recovery clocking, release and reconnection
	task automatic test_stuck_start;
		int c;
		restart(6'h34);
		tick(3 * SIM_TMO);
		check(fault_n, 1'b1, "fault in lockout");
		set(6'h14);
		await(1, 1'b0, SIM_TMO + 10, c);
		check(c >= SIM_TMO, 1'b1, "fault early");
		check(ready, 1'b0, "joined while stuck");
		await(2, 1'b0, REC_WAIT_CYC + 10, c);
		check(c >= REC_WAIT_CYC, 1'b1, "recovery early");
		await(2, 1'b1, REC_HALF_CYC + 5, c);
		check(c >= REC_HALF_CYC - 2, 1'b1, "pulse width");
		set(6'h10);
		await(1, 1'b1, 20, c);
		check(ready, 1'b0, "joined at fault release");
		await(0, 1'b1, SIM_IDLE + 20, c);
		tick(REC_HALF_CYC);
		check(oe_n[3], 1'b1, "clocking went on");
		$display("test_stuck_start done");
	endtask

	// Start-up conditions with enable, busy backplane and low card line
	task automatic test_connect;
		int c;
		restart(6'h02);
		tick(20);
		check(ready, 1'b0, "joined while disabled");
		set(6'h12);
		tick(SIM_IDLE + 20);
		check(ready, 1'b0, "joined with bp busy");
		set(6'h18);
		tick(SIM_IDLE + 20);
		check(ready, 1'b0, "joined with card low");
		set(6'h10);
		await(0, 1'b1, 10, c);
		$display("test_connect done");
	endtask

	// Stop after link clock traffic, then copying and release of joined lines
	task automatic test_stop_join;
		int c;
		restart(6'h11);
		repeat (6) begin
			set(6'h13);
			tick(3);
			set(6'h11);
			tick(3);
		end
		check(ready, 1'b0, "joined mid frame");
		set(6'h10);
		await(0, 1'b1, 10, c);
		set(6'h11);
		tick(8);
		check(oe_n[2], 1'b0, "card data not pulled");
		set(6'h15);
		set(6'h14);
		tick(12);
		check(level[0], 1'b0, "bp data released early");
		set(6'h18);
		tick(8);
		check(oe_n[1], 1'b0, "bp clock not pulled");
		set(6'h10);
		tick(12);
		check(oe_n == 4'hF, 1'b1, "lines still pulled");
		check(ready, 1'b1, "link dropped");
		set(6'h00);
		tick(5);
		check(ready, 1'b0, "ready with enable low");
		$display("test_stop_join done");
	endtask

	// Stuck fault while joined, enable low, forced join and timer restart
	task automatic test_forced;
		int c;
		restart(6'h10);
		await(0, 1'b1, SIM_IDLE + 20, c);
		set(6'h18);
		await(1, 1'b0, SIM_TMO + 10, c);
		check(ready, 1'b0, "joined after fault");
		set(6'h08);
		tick(REC_WAIT_CYC + 200);
		check(oe_n[3], 1'b1, "clocking while disabled");
		set(6'h18);
		tick(4);
		check(ready & fault_n, 1'b1, "no forced join");
		tick(SIM_TMO - 20);
		check(fault_n, 1'b1, "timer not restarted");
		await(1, 1'b0, 40, c);
		$display("test_forced done");
	endtask

	// Main sequence
	initial begin
		test_stuck_start();
		test_connect();
		test_stop_join();
		test_forced();
		end_of_test();
	end
endmodule // twbc_ctrl_tb

// ---- verilog/twbc_ctrl.sv ----
`timescale 1ns/10ps

// Behaviour
// - Stay in lockout, ignoring both segments, while supply lockout is asserted.
// - After lockout, watch backplane for stop or idle before connecting.
// - After stop or idle, also require both card lines high.
// - With all conditions met, join the segments and raise ready.
// - While joined, a low on either side is copied to the other side.
// - A joined pair returns high when the side that pulled it low releases; a low still held on the other side is copied back after settling.
// - Stuck timer runs while either card line is low.
// - Stuck timer clears when both card lines are high together, in lockout, or on a forced join.
// - Timer expiry asserts fault low and breaks the connection.
// - Wait at least 40 us after the fault before recovery clocking.
// - Recovery sends at most 16 clock pulses near 8.5 kHz on card clock.
// - Card lines high again release fault; reconnect via full start-up conditions.
// - Stuck at power-up: stay apart, fault after timeout, then recover.
// - Ready is high while joined and low otherwise.
// - Enable low isolates, drops ready and suppresses recovery clocking.
// - Enable rising normally waits for start-up conditions before joining.
// - Enable rising after a fault joins immediately, skipping idle conditions.
// - That forced join restarts the stuck timer and keeps it running.
module twbc_ctrl
	import twbc_pkg::*;
#(
	parameter int TIMEOUT_CYC_P = TIMEOUT_CYC,
	parameter int IDLE_CYC_P    = IDLE_CYC
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic nrst,
	// Supply and enable
	input  wire logic supplyLockout,
	input  wire logic enable,
	// Backplane data line
	input  wire logic backplaneDataIn,
	output logic      backplaneDataOut,
	output logic      backplaneDataOe_n,
	// Backplane clock line
	input  wire logic backplaneClockIn,
	output logic      backplaneClockOut,
	output logic      backplaneClockOe_n,
	// Card data line
	input  wire logic cardDataIn,
	output logic      cardDataOut,
	output logic      cardDataOe_n,
	// Card clock line
	input  wire logic cardClockIn,
	output logic      cardClockOut,
	output logic      cardClockOe_n,
	// Status
	output logic      ready,
	output logic      fault_n
);

	localparam logic [TMR_W-1:0]   TMR_MAX   = TMR_W'(TIMEOUT_CYC_P);
	localparam logic [IDLE_W-1:0]  IDLE_MAX  = IDLE_W'(IDLE_CYC_P);
	localparam logic [REC_W-1:0]   WAIT_LAST = REC_W'(REC_WAIT_CYC - 1);
	localparam logic [REC_W-1:0]   HALF_LAST = REC_W'(REC_HALF_CYC - 1);
	localparam logic [REC_W-1:0]   SETTLE_C  = REC_W'(JOIN_SETTLE_CYC);
	localparam logic [PULSE_W-1:0] PULSE_MAX = PULSE_W'(REC_PULSES);

	typedef struct packed {
		twbc_state_e        state;
		logic [TMR_W-1:0]   stuckTmr;
		logic [IDLE_W-1:0]  idleCnt;
		logic [REC_W-1:0]   recCnt;
		logic [PULSE_W-1:0] pulseCnt;
		logic               recLow;
		logic               faultSeen;
		logic               enPrev;
		logic               bpDataPrev;
		logic               ready;
		logic               faultN;
	} twbc_core_s;

	twbc_core_s s_r;
	twbc_core_s s_nxt;

	logic [SYNC_W-1:0] syncLv;
	logic              sLock;
	logic              sEn;
	logic              sBpData;
	logic              sBpClk;
	logic              sCardData;
	logic              sCardClk;
	logic              joined;
	logic              pullBpData;
	logic              pullCardData;
	logic              pullBpClk;
	logic              pullCardClk;
	logic              cardHigh;
	logic              bpStop;
	logic              bpIdle;
	logic              enRise;
	logic              timedOut;

	// Saturating increment shared by the idle counter and the stuck timer
	function automatic logic [TMR_W-1:0] satInc(input logic [TMR_W-1:0] v,
		input logic [TMR_W-1:0] lim);
		satInc = (v == lim) ? v : v + 1'b1;
	endfunction

	// Every pin level and enable passes two flip-flops first
	twbc_sync u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.asyncIn  ({cardClockIn, cardDataIn, backplaneClockIn, backplaneDataIn,
			enable, supplyLockout}),
		.syncOut  (syncLv)
	);

	assign sLock     = syncLv[SY_LOCK];
	assign sEn       = syncLv[SY_EN];
	assign sBpData   = syncLv[SY_BP_DATA];
	assign sBpClk    = syncLv[SY_BP_CLK];
	assign sCardData = syncLv[SY_CARD_DATA];
	assign sCardClk  = syncLv[SY_CARD_CLK];

	// Wired-AND joining of the two pairs
	assign joined = (s_r.state == ST_CONNECTED);

	twbc_join u_join_data (
		.core_clk (core_clk),
		.nrst     (nrst),
		.joined   (joined),
		.bpLow    (~sBpData),
		.cardLow  (~sCardData),
		.pullBp   (pullBpData),
		.pullCard (pullCardData)
	);

	twbc_join u_join_clk (
		.core_clk (core_clk),
		.nrst     (nrst),
		.joined   (joined),
		.bpLow    (~sBpClk),
		.cardLow  (~sCardClk),
		.pullBp   (pullBpClk),
		.pullCard (pullCardClk)
	);

	// Bus condition decode
	assign cardHigh = sCardData & sCardClk;
	assign bpStop   = sBpClk & sBpData & ~s_r.bpDataPrev;
	assign bpIdle   = (s_r.idleCnt == IDLE_MAX);
	assign enRise   = sEn & ~s_r.enPrev;
	assign timedOut = (s_r.stuckTmr == TMR_MAX);

	// Next-state logic
	always_comb begin
		s_nxt            = s_r;
		s_nxt.enPrev     = sEn;
		s_nxt.bpDataPrev = sBpData;

		// Backplane idle counter
		if (sBpData & sBpClk) begin
			s_nxt.idleCnt = IDLE_W'(satInc(TMR_W'(s_r.idleCnt), TMR_W'(IDLE_MAX)));
		end else begin
			s_nxt.idleCnt = '0;
		end

		// Stuck-bus timer
		if (cardHigh) begin
			s_nxt.stuckTmr = '0;
		end else begin
			s_nxt.stuckTmr = satInc(s_r.stuckTmr, TMR_MAX);
		end

		unique case (s_r.state)
			ST_LOCKOUT: begin
				s_nxt.idleCnt  = '0;
				s_nxt.stuckTmr = '0;
				s_nxt.state    = ST_WAIT_END;
			end
			ST_WAIT_END: begin
				if (timedOut) begin
					s_nxt.state = ST_FLT_WAIT;
				end else if (sEn && (bpStop || bpIdle)) begin
					s_nxt.state = ST_WAIT_CARD;
				end
			end
			ST_WAIT_CARD: begin
				if (timedOut) begin
					s_nxt.state = ST_FLT_WAIT;
				end else if (!sEn) begin
					s_nxt.state = ST_WAIT_END;
				end else if (cardHigh) begin
					s_nxt.state = ST_CONNECTED;
				end
			end
			ST_CONNECTED: begin
				if (timedOut) begin
					s_nxt.state = ST_FLT_WAIT;
				end else if (!sEn) begin
					s_nxt.state = ST_WAIT_END;
				end
			end
			ST_FLT_WAIT: begin
				if (cardHigh) begin
					s_nxt.state  = ST_WAIT_END;
					s_nxt.faultN = 1'b1;
				end else if (sEn) begin
					s_nxt.recCnt = s_r.recCnt + 1'b1;
					if (s_r.recCnt == WAIT_LAST) begin
						s_nxt.state    = ST_RECOVER;
						s_nxt.recCnt   = '0;
						s_nxt.recLow   = 1'b1;
						s_nxt.pulseCnt = '0;
					end
				end
			end
			ST_RECOVER: begin
				if (!sEn) begin
					s_nxt.recLow = 1'b0;
					s_nxt.recCnt = '0;
				end else if (!s_r.recLow && s_r.recCnt >= SETTLE_C && cardHigh) begin
					s_nxt.state  = ST_WAIT_END;
					s_nxt.faultN = 1'b1;
					s_nxt.recCnt = '0;
				end else if (s_r.recCnt == HALF_LAST) begin
					s_nxt.recCnt = '0;
					if (s_r.recLow) begin
						s_nxt.recLow   = 1'b0;
						s_nxt.pulseCnt = s_r.pulseCnt + 1'b1;
					end else if (s_r.pulseCnt == PULSE_MAX) begin
						s_nxt.state = ST_FLT_HOLD;
					end else begin
						s_nxt.recLow = 1'b1;
					end
				end else begin
					s_nxt.recCnt = s_r.recCnt + 1'b1;
				end
			end
			ST_FLT_HOLD: begin
				if (cardHigh) begin
					s_nxt.state  = ST_WAIT_END;
					s_nxt.faultN = 1'b1;
				end
			end
		endcase

		// Declaring a stuck bus from any waiting or joined state
		if (s_nxt.state == ST_FLT_WAIT && s_r.state != ST_FLT_WAIT) begin
			s_nxt.faultN    = 1'b0;
			s_nxt.faultSeen = 1'b1;
			s_nxt.recCnt    = '0;
			s_nxt.recLow    = 1'b0;
		end

		// Forced join on enable rise after a fault; a fault declared now wins
		if (s_r.state != ST_LOCKOUT && enRise && s_r.faultSeen &&
			!(s_nxt.state == ST_FLT_WAIT && s_r.state != ST_FLT_WAIT)) begin
			s_nxt.state     = ST_CONNECTED;
			s_nxt.stuckTmr  = '0;
			s_nxt.faultSeen = 1'b0;
			s_nxt.faultN    = 1'b1;
			s_nxt.recLow    = 1'b0;
			s_nxt.recCnt    = '0;
		end

		// Lockout overrides everything
		if (sLock) begin
			s_nxt.state     = ST_LOCKOUT;
			s_nxt.stuckTmr  = '0;
			s_nxt.idleCnt   = '0;
			s_nxt.recCnt    = '0;
			s_nxt.recLow    = 1'b0;
			s_nxt.faultSeen = 1'b0;
			s_nxt.faultN    = FAULT_N_RST;
		end

		s_nxt.ready = (s_nxt.state == ST_CONNECTED);
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_r            <= '0;
			s_r.state      <= ST_LOCKOUT;
			s_r.ready      <= READY_RST;
			s_r.faultN     <= FAULT_N_RST;
			s_r.bpDataPrev <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Open-drain pins: value low, enable low while pulling
	assign backplaneDataOut   = 1'b0;
	assign backplaneClockOut  = 1'b0;
	assign cardDataOut        = 1'b0;
	assign cardClockOut       = 1'b0;
	assign backplaneDataOe_n  = ~pullBpData;
	assign backplaneClockOe_n = ~pullBpClk;
	assign cardDataOe_n       = ~pullCardData;
	assign cardClockOe_n      = ~(pullCardClk | (s_r.recLow && s_r.state == ST_RECOVER));

	// Status outputs
	assign ready   = s_r.ready;
	assign fault_n = s_r.faultN;

endmodule // twbc_ctrl

// ---- verilog/twbc_join.sv ----
`timescale 1ns/10ps

module twbc_join
	import twbc_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic nrst,
	// Control
	input  wire logic joined,
	// Synchronised line levels, high when the line is low
	input  wire logic bpLow,
	input  wire logic cardLow,
	// Pull-down requests
	output logic      pullBp,
	output logic      pullCard
);

	typedef struct packed {
		twbc_owner_e         owner;
		logic [SETTLE_W-1:0] settleCnt;
		logic                pullBp;
		logic                pullCard;
	} twbc_join_s;

	twbc_join_s s_r;
	twbc_join_s s_nxt;

	// Owner tracking keeps our own pull-down from latching the pair low
	always_comb begin
		s_nxt = s_r;
		if (!joined) begin
			s_nxt.owner     = JO_NONE;
			s_nxt.settleCnt = '0;
			s_nxt.pullBp    = 1'b0;
			s_nxt.pullCard  = 1'b0;
		end else begin
			unique case (s_r.owner)
				JO_NONE: begin
					if (bpLow) begin
						s_nxt.owner    = JO_BP;
						s_nxt.pullCard = 1'b1;
					end else if (cardLow) begin
						s_nxt.owner  = JO_CARD;
						s_nxt.pullBp = 1'b1;
					end
				end
				JO_BP: begin
					if (!bpLow) begin
						s_nxt.owner     = JO_SETTLE;
						s_nxt.pullCard  = 1'b0;
						s_nxt.settleCnt = '0;
					end
				end
				JO_CARD: begin
					if (!cardLow) begin
						s_nxt.owner     = JO_SETTLE;
						s_nxt.pullBp    = 1'b0;
						s_nxt.settleCnt = '0;
					end
				end
				JO_SETTLE: begin
					s_nxt.settleCnt = s_r.settleCnt + 1'b1;
					if (s_r.settleCnt == SETTLE_W'(JOIN_SETTLE_CYC - 1)) begin
						s_nxt.owner = JO_NONE;
					end
				end
				default: begin
					s_nxt.owner    = JO_NONE;
					s_nxt.pullBp   = 1'b0;
					s_nxt.pullCard = 1'b0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_r.owner     <= JO_NONE;
			s_r.settleCnt <= '0;
			s_r.pullBp    <= 1'b0;
			s_r.pullCard  <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pullBp   = s_r.pullBp;
	assign pullCard = s_r.pullCard;

endmodule // twbc_join

// ---- verilog/twbc_sync.sv ----
`timescale 1ns/10ps

module twbc_sync
	import twbc_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [SYNC_W-1:0] asyncIn,
	output logic      [SYNC_W-1:0] syncOut
);

	typedef struct packed {
		logic [SYNC_W-1:0] stage1;
		logic [SYNC_W-1:0] stage2;
	} twbc_sync_s;

	twbc_sync_s s_r;
	twbc_sync_s s_nxt;

	// Two-stage shift; only stage2 is read outside
	always_comb begin
		s_nxt        = s_r;
		s_nxt.stage1 = asyncIn;
		s_nxt.stage2 = s_r.stage1;
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_r.stage1 <= SYNC_RST;
			s_r.stage2 <= SYNC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign syncOut = s_r.stage2;

endmodule // twbc_sync
